// file: lccsa_pkg.sv
// constants for the logic cluster carry-select adder
// Summary of operation
// - add_sub_select makes every cell compute A plus B or A minus B.
// - subtraction inverts all B bits and forces the lowest carry in to one.
// - the adder's lowest bit sits in cell zero, where subtract sets carry in.
// - each cell has a four-input function generator, register and carry logic.
// - each cell runs in normal or dynamic arithmetic configuration, never both.
// - each cell takes four data inputs, two chain carries, cluster carry, cascade.
// - arithmetic uses two-input functions: sums and carries for carry zero and one.
// - cluster carry-in picks a chain; that chain's level picks the sum.
// - each chain's carry in selects that chain's carry out to the next bit.
// - arithmetic cells present registered and unregistered results.
// - options: clock enable, count enable, clear, load, add/subtract.
// - synchronous clear and load act on every cluster register together.
// - output register can be bypassed or hold a running sum.
// - final chain carry out drives finalCarry onto general routing directly, with no cell.
// - cluster is a ten-bit adder; chains continue into further clusters.
// - cluster registers cascade into a shift register independent of functions.
// - function generators cascade through a chain for wider functions.
// - register output can feed its own function generator; both outputs offered.
// - cluster controls come from eight row clocks 7..0 and local routing.
package lccsa_pkg;
  localparam int LCCSA_CELLS = 10;
  localparam int LCCSA_ROW_CLKS = 8;
  localparam int LCCSA_SEL_W = 3;
  localparam logic LCCSA_REG_RST = 1'h0;
  typedef enum logic [1:0]
  {
    LCCSA_SRC_LOCAL = 2'h0,
    LCCSA_SRC_ROWCLK = 2'h1,
    LCCSA_SRC_ONE = 2'h2,
    LCCSA_SRC_ZERO = 2'h3
  } lccsa_src_t;
endpackage

// file: lccsa_cluster.sv
// one logic cluster of carry-select cells
`timescale 1ns/1ps
module lccsa_cluster
  import lccsa_pkg::*;
#(
  parameter int CELLS = LCCSA_CELLS
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // configuration
  input wire logic arithMode,
  input wire logic [15:0] lutMask [CELLS],
  input wire logic [CELLS-1:0] packFeedback,
  input wire logic [CELLS-1:0] useCascade,
  input wire logic [CELLS-1:0] lutChainUse,
  input wire logic [CELLS-1:0] bypassReg,
  // cluster control sources
  input wire logic [LCCSA_ROW_CLKS-1:0] rowClk,
  input wire logic [3:0] localCtrl,
  input wire lccsa_src_t [3:0] ctrlSrc,
  input wire logic [LCCSA_SEL_W-1:0] ctrlSel [4],
  // cell data inputs
  input wire logic [CELLS-1:0] operand_a,
  input wire logic [CELLS-1:0] operand_b,
  input wire logic [CELLS-1:0] dataC,
  input wire logic [CELLS-1:0] dataD,
  input wire logic [CELLS-1:0] loadData,
  // carry chain from preceding cluster
  input wire logic clusterCin,
  input wire logic chain_zero_cin,
  input wire logic chain_one_cin,
  input wire logic cascadeIn,
  input wire logic lutChainIn,
  // cell outputs
  output logic [CELLS-1:0] combOut,
  output logic [CELLS-1:0] regOut,
  output logic [CELLS-1:0] cellOut,
  // chain outputs to next cluster
  output logic chain_zero_cout,
  output logic chain_one_cout,
  output logic clusterCout,
  output logic finalCarry,
  output logic cascadeOut,
  output logic lutChainOut
);

  // cluster-wide controls: 0 clock enable, 1 sync clear, 2 sync load, 3 add_sub_select
  logic [3:0] ctrl;
  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      case (ctrlSrc[k])
        LCCSA_SRC_LOCAL: ctrl[k] = localCtrl[k];
        LCCSA_SRC_ROWCLK: ctrl[k] = rowClk[ctrlSel[k]];
        LCCSA_SRC_ONE: ctrl[k] = 1'h1;
        LCCSA_SRC_ZERO: ctrl[k] = 1'h0;
        default: ctrl[k] = 1'h0;
      endcase
    end
  end

  logic clkEn, syncClr, syncLoad, addSubSelect;
  assign clkEn = ctrl[0];
  assign syncClr = ctrl[1];
  assign syncLoad = ctrl[2];
  assign addSubSelect = ctrl[3];

  // dataC is count enable per cell in arithmetic mode; dataD is used only in normal mode
  logic subtract;
  assign subtract = arithMode & ~addSubSelect;

  logic [CELLS:0] c0, c1;
  logic [CELLS:0] lutChain;
  logic [CELLS:0] shiftChain;
  logic [CELLS-1:0] cellReg;
  logic [CELLS-1:0] bEff, sum0, sum1, lutOut, next_reg, useChain1;

  // cell zero: subtract forces carry in of the lowest bit to one
  assign c0[0] = subtract ? 1'h1 : chain_zero_cin;
  assign c1[0] = subtract ? 1'h1 : chain_one_cin;
  assign lutChain[0] = lutChainIn;
  assign shiftChain[0] = cascadeIn;

  always_comb
  begin
    for (int i = 0; i < CELLS; i++)
    begin
      // subtract inverts every B bit before the sums and carries
      bEff[i] = operand_b[i] ^ subtract;
      // two-input sums assuming carry 0 and carry 1
      sum0[i] = operand_a[i] ^ bEff[i];
      sum1[i] = ~(operand_a[i] ^ bEff[i]);
      // chain carries selected by each chain's own carry in
      c0[i+1] = c0[i] ? (operand_a[i] | bEff[i]) : (operand_a[i] & bEff[i]);
      c1[i+1] = c1[i] ? (operand_a[i] | bEff[i]) : (operand_a[i] & bEff[i]);
      useChain1[i] = clusterCin ? c1[i] : c0[i];
      // normal mode: full four-input lookup, third input may be own register or chain
      if (arithMode)
        lutOut[i] = useChain1[i] ? sum1[i] : sum0[i];
      else
        lutOut[i] = lutMask[i][{dataD[i],
          packFeedback[i] ? cellReg[i] : (lutChainUse[i] ? lutChain[i] : dataC[i]),
          operand_b[i], operand_a[i]}];
      lutChain[i+1] = lutOut[i];
      shiftChain[i+1] = cellReg[i];
      // register priority: clear, load, cascade, count, plain capture
      next_reg[i] = cellReg[i];
      if (clkEn)
      begin
        if (syncClr)
          next_reg[i] = 1'h0;
        else if (syncLoad)
          next_reg[i] = loadData[i];
        else if (useCascade[i])
          next_reg[i] = shiftChain[i];
        else if (!arithMode || dataC[i])
          next_reg[i] = lutOut[i];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      cellReg <= {CELLS{LCCSA_REG_RST}};
    else
      cellReg <= next_reg;
  end

  assign combOut = lutOut;
  assign regOut = cellReg;
  assign cellOut = bypassReg & lutOut | ~bypassReg & cellReg;
  assign chain_zero_cout = c0[CELLS];
  assign chain_one_cout = c1[CELLS];
  assign clusterCout = clusterCin ? c1[CELLS] : c0[CELLS];
  assign finalCarry = clusterCout;
  assign cascadeOut = shiftChain[CELLS];
  assign lutChainOut = lutChain[CELLS];

  // assertions
  a_sub_lsb_carry: assert property (@(posedge clk_sys) disable iff (sys_rst)
    subtract |-> (c0[0] && c1[0]))
    else $error("subtract did not force lowest carry");
  a_add_result: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (arithMode && addSubSelect && !clusterCin && !chain_zero_cin)
    |-> (combOut == CELLS'(operand_a + operand_b)))
    else $error("adder sum wrong");
  a_sub_result: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (arithMode && !addSubSelect && !clusterCin)
    |-> (combOut == CELLS'(operand_a - operand_b)))
    else $error("subtract result wrong");
  a_clear_wins: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clkEn && syncClr) |=> (regOut == '0))
    else $error("sync clear not applied");
  a_load_all: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clkEn && !syncClr && syncLoad) |=> (regOut == $past(loadData)))
    else $error("sync load not applied");
  a_hold_no_en: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !clkEn |=> $stable(regOut))
    else $error("register moved without clock enable");
  a_reg_tracks: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clkEn && !syncClr && !syncLoad && !arithMode && useCascade == '0)
    |=> (regOut == $past(combOut)))
    else $error("register did not capture result");
  a_carry_out: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (arithMode && addSubSelect && !clusterCin && !chain_zero_cin)
    |-> (finalCarry == (({1'h0, operand_a} + {1'h0, operand_b}) >> CELLS)))
    else $error("final carry wrong");
  a_shift_chain: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clkEn && !syncClr && !syncLoad && useCascade[0]) |=> (regOut[0] == $past(cascadeIn)))
    else $error("cascade shift wrong");

  // reference sums for the arithmetic checks
  logic [CELLS:0] refAdd, refAdd1, refSub;
  assign refAdd = {1'h0, operand_a} + {1'h0, operand_b};
  assign refAdd1 = {1'h0, operand_a} + {1'h0, operand_b} + (CELLS+1)'(1);
  assign refSub = {1'h0, operand_a} + {1'h0, ~operand_b} + (CELLS+1)'(1);

  a_add_carry_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (arithMode && addSubSelect && !chain_zero_cin)
    |-> (chain_zero_cout == refAdd[CELLS]))
    else $error("chain zero carry out wrong");

  a_add_carry_one: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (arithMode && addSubSelect && chain_one_cin)
    |-> (chain_one_cout == refAdd1[CELLS]))
    else $error("chain one carry out wrong");

  a_chain_one_sum: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (arithMode && addSubSelect && clusterCin && chain_one_cin)
    |-> (combOut == refAdd1[CELLS-1:0]))
    else $error("chain one sum wrong");

  a_chain_one_cout: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (arithMode && addSubSelect && clusterCin && chain_one_cin)
    |-> (finalCarry == refAdd1[CELLS]))
    else $error("chain one final carry wrong");

  a_sub_carry_out: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (arithMode && !addSubSelect)
    |-> (finalCarry == refSub[CELLS]))
    else $error("subtract carry out wrong");

  a_sub_both_chains: assert property (@(posedge clk_sys) disable iff (sys_rst)
    subtract
    |-> ((chain_zero_cout == refSub[CELLS]) && (chain_one_cout == refSub[CELLS])))
    else $error("subtract chain carries differ");

  a_sub_lsb_cell: assert property (@(posedge clk_sys) disable iff (sys_rst)
    subtract
    |-> (combOut[0] == (operand_a[0] ^ operand_b[0])))
    else $error("subtract lowest bit wrong");

  a_add_lsb_cell: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (arithMode && addSubSelect && !clusterCin)
    |-> (combOut[0] == (operand_a[0] ^ operand_b[0] ^ chain_zero_cin)))
    else $error("add lowest bit wrong");

  a_cout_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clusterCout == (clusterCin ? chain_one_cout : chain_zero_cout))
    else $error("cluster carry out not from selected chain");

  a_final_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
    finalCarry == clusterCout)
    else $error("final carry not routed");

  a_mode_no_sub: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !arithMode
    |-> !subtract)
    else $error("subtract active in normal mode");

  a_sel_high_add: assert property (@(posedge clk_sys) disable iff (sys_rst)
    addSubSelect
    |-> !subtract)
    else $error("subtract active while add selected");

  a_count_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clkEn && !syncClr && !syncLoad && arithMode && useCascade == '0 && dataC == '0)
    |=> $stable(regOut))
    else $error("register moved without count enable");

  a_count_capture: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clkEn && !syncClr && !syncLoad && arithMode && useCascade == '0 && dataC == '1)
    |=> (regOut == $past(combOut)))
    else $error("register did not capture sum");

  a_load_beats_cascade: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clkEn && !syncClr && syncLoad && useCascade != '0)
    |=> (regOut == $past(loadData)))
    else $error("load lost to cascade");

  a_clear_beats_ld: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clkEn && syncClr && syncLoad)
    |=> (regOut == '0))
    else $error("clear lost to load");

  a_rowclk_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ctrlSrc[0] == LCCSA_SRC_ROWCLK && !rowClk[ctrlSel[0]])
    |=> $stable(regOut))
    else $error("row clock enable low but register moved");

  a_rowclk_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ctrlSrc[0] == LCCSA_SRC_ROWCLK && rowClk[ctrlSel[0]] && !syncClr && syncLoad)
    |=> (regOut == $past(loadData)))
    else $error("row clock enable did not admit load");

  a_cascade_out: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cascadeOut == regOut[CELLS-1])
    else $error("cascade out not top register");

  a_cascade_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clkEn && !syncClr && !syncLoad && useCascade[1])
    |=> (regOut[1] == $past(regOut[0])))
    else $error("register chain did not shift");

  a_lut_chain_out: assert property (@(posedge clk_sys) disable iff (sys_rst)
    lutChainOut == combOut[CELLS-1])
    else $error("lut chain out not top result");

  a_normal_lut: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!arithMode && !packFeedback[0] && !lutChainUse[0])
    |-> (combOut[0] == lutMask[0][{dataD[0], dataC[0], operand_b[0], operand_a[0]}]))
    else $error("normal mode lookup wrong");

  a_pack_feedback: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!arithMode && packFeedback[0])
    |-> (combOut[0] == lutMask[0][{dataD[0], regOut[0], operand_b[0], operand_a[0]}]))
    else $error("packed register not fed back");

  a_bypass_path: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cellOut == ((bypassReg & combOut) | (~bypassReg & regOut)))
    else $error("cell output path wrong");

  a_reset_clear: assert property (@(posedge clk_sys)
    sys_rst
    |-> (regOut == '0))
    else $error("register not cleared in reset");

endmodule // lccsa_cluster

// file: lccsa_fabric.sv
// routing fabric model feeding cluster controls
`timescale 1ns/1ps
module lccsa_fabric
  import lccsa_pkg::*;
(
  // requested controls
  input wire logic ce,
  input wire logic clr,
  input wire logic ld,
  input wire logic addSub,
  input wire logic [LCCSA_CELLS-1:0] cntEn,
  // drive toward the cluster
  output logic [3:0] localCtrl,
  output logic [LCCSA_CELLS-1:0] dataC
);
  assign localCtrl = {addSub, ld, clr, ce};
  assign dataC = cntEn;
endmodule // lccsa_fabric

// file: lccsa_cluster_bench.sv
// self-checking bench for the carry-select cluster
`timescale 1ns/1ps
module lccsa_cluster_bench
  import lccsa_pkg::*;
;
  logic clk_sys = 0, sys_rst = 1, ce = 1, clr = 0, ld = 0, addSub = 1, cin = 0;
  logic [15:0] lutMask [LCCSA_CELLS];
  logic [2:0] ctrlSel [4];
  lccsa_src_t [3:0] ctrlSrc;
  logic [LCCSA_CELLS-1:0] a = 0, b = 0, byp = 0, ldat = 10'h2A5, cntEn = '1;
  logic [LCCSA_CELLS-1:0] dataC, combOut, regOut, cellOut;
  logic [3:0] localCtrl;
  logic c0, c1, cout, fc, casc, lco;
  logic arithMode = 1, cascIn = 0;
  logic [7:0] rowClk = 8'h00;
  logic [LCCSA_CELLS-1:0] pack = 0, useC = 0;
  int n_errors = 0, checked = 0;
  lccsa_fabric u_lccsa_fabric (.ce(ce), .clr(clr), .ld(ld), .addSub(addSub), .cntEn(cntEn),
    .localCtrl(localCtrl), .dataC(dataC));
  lccsa_cluster u_lccsa_cluster (.clk_sys(clk_sys), .sys_rst(sys_rst), .arithMode(arithMode),
    .lutMask(lutMask), .packFeedback(pack), .useCascade(useC), .lutChainUse(10'h000),
    .bypassReg(byp), .rowClk(rowClk), .localCtrl(localCtrl), .ctrlSrc(ctrlSrc),
    .ctrlSel(ctrlSel), .operand_a(a), .operand_b(b), .dataC(dataC), .dataD(10'h000),
    .loadData(ldat), .clusterCin(cin), .chain_zero_cin(1'b0), .chain_one_cin(1'b1),
    .cascadeIn(cascIn), .lutChainIn(1'b0), .combOut(combOut), .regOut(regOut),
    .cellOut(cellOut), .chain_zero_cout(c0), .chain_one_cout(c1), .clusterCout(cout),
    .finalCarry(fc), .cascadeOut(casc), .lutChainOut(lco));
  initial forever #25 clk_sys = ~clk_sys;
  task chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  task end_of_test;
    $display("n_errors %0d checked %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one add or subtract, then the registered copy
  task arith(input logic as, input logic ci, input logic [9:0] x, input logic [9:0] y);
    logic [10:0] e;
    @(negedge clk_sys);
    addSub = as;
    cin = ci;
    a = x;
    b = y;
    e = as ? {1'b0, x} + {1'b0, y} + ci : {1'b0, x} + {1'b0, ~y} + 11'h001;
    #1 chk("sum", e, {fc, combOut});
    chk("carry", {10'h000, e[10]}, {10'h000, cout});
    @(negedge clk_sys);
    chk("reg", {1'b0, e[9:0]}, {1'b0, regOut});
  endtask
  // controls set at the current falling edge, judged after one rising edge
  task ctl(input logic e, input logic c, input logic l, input logic [9:0] x);
    ce = e;
    clr = c;
    ld = l;
    @(negedge clk_sys);
    chk("ctl", {1'b0, x}, {1'b0, regOut});
  endtask
  // cells 0 and 1 on the register chain, cascade input high
  task shift_chk;
    @(negedge clk_sys);
    useC = 10'h003;
    cascIn = 1'b1;
    @(negedge clk_sys);
    chk("shift", 11'h2A7, {1'b0, regOut});
    chk("cascadeOut", 11'h001, {10'h000, casc});
  endtask
  // clock enable taken from row clock 5
  task rowclk_chk;
    @(negedge clk_sys);
    useC = '0;
    cascIn = 1'b0;
    ctrlSel[0] = 3'h5;
    ctrlSrc[0] = LCCSA_SRC_ROWCLK;
    ld = 1'b1;
    @(negedge clk_sys);
    chk("rowClkHold", 11'h2A7, {1'b0, regOut});
    rowClk = 8'h20;
    @(negedge clk_sys);
    chk("rowClkLoad", 11'h2A5, {1'b0, regOut});
    ld = 1'b0;
    ctrlSrc[0] = LCCSA_SRC_LOCAL;
    rowClk = 8'h00;
  endtask
  // normal mode lookup, then own register fed back, then output paths
  task normal_chk;
    @(negedge clk_sys);
    arithMode = 1'b0;
    a = 10'h155;
    foreach (lutMask[i]) lutMask[i] = 16'hAAAA;
    #1 chk("lut", 11'h155, {1'b0, combOut});
    chk("lutChain", 11'h000, {10'h000, lco});
    @(negedge clk_sys);
    chk("capture", 11'h155, {1'b0, regOut});
    pack = '1;
    foreach (lutMask[i]) lutMask[i] = 16'hF0F0;
    #1 chk("pack", 11'h155, {1'b0, combOut});
    chk("regPath", 11'h155, {1'b0, cellOut});
    @(negedge clk_sys);
    byp = '1;
    #1 chk("bypass", 11'h155, {1'b0, cellOut});
  endtask
  initial
  begin
    foreach (lutMask[i]) lutMask[i] = 16'h0000;
    foreach (ctrlSel[i]) ctrlSel[i] = 3'h0;
    foreach (ctrlSrc[i]) ctrlSrc[i] = LCCSA_SRC_LOCAL;
    repeat (3) @(negedge clk_sys);
    sys_rst = 0;
    chk("rst", 11'h000, {1'b0, regOut});
    arith(1, 0, 10'h155, 10'h0AB);
    arith(1, 1, 10'h3FF, 10'h000);
    arith(0, 0, 10'h000, 10'h001);
    arith(0, 1, 10'h200, 10'h1FF);
    a = 10'h0F0;
    ctl(0, 0, 0, 10'h001);
    ctl(1, 1, 1, 10'h000);
    ctl(1, 0, 1, 10'h2A5);
    ctl(0, 1, 0, 10'h2A5);
    cntEn = 10'h000;
    ctl(1, 0, 0, 10'h2A5);
    shift_chk;
    rowclk_chk;
    normal_chk;
    sys_rst = 1;
    #1 chk("arst", 11'h000, {1'b0, regOut});
    end_of_test;
  end
  initial
  begin
    #20000;
    n_errors++;
    end_of_test;
  end
endmodule // lccsa_cluster_bench
